// >>> rtl/ssrb_pkg.sv
// package: constants and carriers for the synth serial register bank
package ssrb_pkg;
  // frame lengths in bits for length-keyed access
  localparam int unsigned LEN_CTRL  = 8;
  localparam int unsigned LEN_HOLD  = 16;
  localparam int unsigned LEN_MAIN  = 24;
  localparam int unsigned LEN_CONV  = 32;
  // address nibbles for conventional access
  localparam logic [3:0] ADDR_DAC   = 4'h3;
  localparam logic [3:0] ADDR_SHOLD = 4'h4;
  localparam logic [3:0] ADDR_SREF  = 4'h5;
  localparam logic [3:0] ADDR_MAIN  = 4'h6;
  localparam logic [3:0] ADDR_MHOLD = 4'h7;
  localparam logic [3:0] ADDR_CTRL  = 4'h8;
  // reset values (power-up defaults)
  localparam logic [7:0]  CTRL_RST  = 8'h03;
  localparam logic [23:0] SREF_RST  = 24'h000000;
  localparam logic [23:0] MAIN_RST  = 24'h000000;
  localparam logic [15:0] HOLD_RST  = 16'h0000;
  localparam logic [15:0] DAC_RST   = 16'h0000;
  // output a function codes
  localparam logic [1:0] OA_GP      = 2'h0;
  localparam logic [1:0] OA_PULSE   = 2'h3;
  // phase detector program code for low pump only
  localparam logic [2:0] PDP_LOW    = 3'h1;

  typedef enum logic [2:0] {
    SSRB_TGT_NONE, SSRB_TGT_CTRL, SSRB_TGT_DAC, SSRB_TGT_SREF,
    SSRB_TGT_SHOLD, SSRB_TGT_MHOLD, SSRB_TGT_MAIN
  } ssrb_tgt_t;

  typedef struct packed {
    logic       out_a;
    logic       out_b_xref;
    logic       out_c;
    logic       detector_tristate;
    logic       sec_detector_float;
    logic       osc_standby;
    logic       main_standby;
    logic       sec_standby;
  } ssrb_ctrl_t;

  typedef struct packed {
    logic [1:0]  coefficient;
    logic [1:0]  out_a_func;
    logic [2:0]  vmult_ctrl;
    logic        test_bit;
    logic [15:0] ratio_x2;
  } ssrb_sref_t;

  typedef struct packed {
    logic        aux_ctrl;
    logic        lock_window;
    logic [2:0]  pd_program;
    logic        current_ratio;
    logic [17:0] ratio;
  } ssrb_main_t;

  // serial frame handed from link domain to core domain
  typedef struct packed {
    ssrb_tgt_t   tgt;
    logic [23:0] data;
  } ssrb_frame_t;
endpackage

// >>> rtl/ssrb_bank.sv
// design: serially loaded control register bank with double buffers
`timescale 1ns/1ps
module ssrb_bank (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                ser_clk,
  input  wire logic                ser_data,
  input  wire logic                ser_enable_n,
  input  wire logic                mode_pin,
  input  wire logic                ref_compare_clock,
  input  wire logic                detector_pulse,
  output ssrb_pkg::ssrb_ctrl_t     ctrl,
  output ssrb_pkg::ssrb_sref_t     sec_ref,
  output ssrb_pkg::ssrb_main_t     main_div,
  output logic [15:0]              main_ref_active,
  output logic [15:0]              sec_div_active,
  output logic [15:0]              main_ref_holding,
  output logic [15:0]              secondary_divider_holding,
  output logic [7:0]               dac1_code,
  output logic [7:0]               dac2_code,
  output logic                     out_a,
  output logic                     out_c_o,
  output logic                     out_c_oe_n,
  output logic                     vmult_on,
  output logic [1:0]               vmult_range,
  output logic                     high_current_pump_en,
  output logic                     low_current_pump_en,
  output logic                     ratio_8to1,
  output logic                     lock_window_long,
  output logic                     ext_ref_sel
);

  ////////////////////////////////////////////////////////////////////////
  // link domain: shift register and bit counter on the serial clock

  logic [31:0] shift_q;
  logic [5:0]  count_q;
  logic        tog_seen_q;
  logic        frame_tog_q;

  // shifts only while enable is low; count restarts each frame
  // a new frame is seen when the frame toggle differs from the copy taken
  // on the previous shift; the toggle settles long before the first bit
  always_ff @(posedge ser_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q    <= 32'h00000000;
      count_q    <= 6'h00;
      tog_seen_q <= 1'b0;
    end
    else if (!ser_enable_n)
    begin
      shift_q    <= {shift_q[30:0], ser_data};
      tog_seen_q <= frame_tog_q;
      if (tog_seen_q != frame_tog_q)
        count_q <= 6'h01;
      else
        count_q <= (count_q == 6'h3f) ? count_q : count_q + 6'h01;
    end
  end

  // frame end is clocked by the rising enable edge, since the serial clock
  // stops outside frames
  function automatic ssrb_pkg::ssrb_tgt_t decode_tgt(
    input logic [5:0]  n,
    input logic [31:0] s
  );
    ssrb_pkg::ssrb_tgt_t t;
    t = ssrb_pkg::SSRB_TGT_NONE;
    if (n == 6'(ssrb_pkg::LEN_CTRL))
      t = ssrb_pkg::SSRB_TGT_CTRL;
    else if (n == 6'(ssrb_pkg::LEN_HOLD))
      t = ssrb_pkg::SSRB_TGT_MHOLD;
    else if (n == 6'(ssrb_pkg::LEN_MAIN))
      t = ssrb_pkg::SSRB_TGT_MAIN;
    else if (n == 6'(ssrb_pkg::LEN_CONV))
    begin
      case (s[27:24])
        ssrb_pkg::ADDR_DAC:   t = ssrb_pkg::SSRB_TGT_DAC;
        ssrb_pkg::ADDR_SHOLD: t = ssrb_pkg::SSRB_TGT_SHOLD;
        ssrb_pkg::ADDR_SREF:  t = ssrb_pkg::SSRB_TGT_SREF;
        ssrb_pkg::ADDR_MAIN:  t = ssrb_pkg::SSRB_TGT_MAIN;
        ssrb_pkg::ADDR_MHOLD: t = ssrb_pkg::SSRB_TGT_MHOLD;
        ssrb_pkg::ADDR_CTRL:  t = ssrb_pkg::SSRB_TGT_CTRL;
        default:              t = ssrb_pkg::SSRB_TGT_NONE;
      endcase
    end
    return t;
  endfunction

  ssrb_pkg::ssrb_frame_t frame_q;

  // frame word is held stable until the next frame, so the core can
  // sample it after the toggle has crossed
  always_ff @(posedge ser_enable_n or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_q     <= '0;
      frame_tog_q <= 1'b0;
    end
    else
    begin
      frame_q.tgt  <= decode_tgt(count_q, shift_q);
      frame_q.data <= shift_q[23:0];
      frame_tog_q  <= ~frame_tog_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crossing into the core clock

  logic [2:0] tog_sync_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tog_sync_q <= 3'h0;
    else
      tog_sync_q <= {tog_sync_q[1:0], frame_tog_q};
  end

  logic                  frame_new;
  ssrb_pkg::ssrb_tgt_t   wr_tgt;
  logic [23:0]           wr_data;

  assign frame_new = tog_sync_q[2] ^ tog_sync_q[1];
  assign wr_tgt    = frame_new ? frame_q.tgt : ssrb_pkg::SSRB_TGT_NONE;
  assign wr_data   = frame_q.data;

  ////////////////////////////////////////////////////////////////////////
  // registers; each changes only on a write to itself, except the active copies, which load on a write to main

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= ssrb_pkg::CTRL_RST;
    else if (wr_tgt == ssrb_pkg::SSRB_TGT_CTRL)
      ctrl <= wr_data[7:0];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sec_ref <= ssrb_pkg::SREF_RST;
    else if (wr_tgt == ssrb_pkg::SSRB_TGT_SREF)
      sec_ref <= wr_data;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dac1_code <= ssrb_pkg::DAC_RST[7:0];
      dac2_code <= ssrb_pkg::DAC_RST[15:8];
    end
    else if (wr_tgt == ssrb_pkg::SSRB_TGT_DAC)
    begin
      dac1_code <= wr_data[7:0];
      dac2_code <= wr_data[15:8];
    end
  end

  // holding registers never reach the dividers directly
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_ref_holding          <= ssrb_pkg::HOLD_RST;
      secondary_divider_holding <= ssrb_pkg::HOLD_RST;
    end
    else
    begin
      if (wr_tgt == ssrb_pkg::SSRB_TGT_MHOLD)
        main_ref_holding <= wr_data[15:0];
      if (wr_tgt == ssrb_pkg::SSRB_TGT_SHOLD)
        secondary_divider_holding <= wr_data[15:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_div        <= ssrb_pkg::MAIN_RST;
      main_ref_active <= ssrb_pkg::HOLD_RST;
      sec_div_active  <= ssrb_pkg::HOLD_RST;
    end
    else if (wr_tgt == ssrb_pkg::SSRB_TGT_MAIN)
    begin
      main_div        <= wr_data;
      main_ref_active <= main_ref_holding;
      sec_div_active  <= secondary_divider_holding;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin and analog control decode

  logic [2:0] mode_sync_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mode_sync_q <= 3'h0;
    else
      mode_sync_q <= {mode_sync_q[1:0], 1'b0} | {2'b00, mode_pin};
  end

  logic [1:0] ref_sync_q;
  logic [1:0] pulse_sync_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_sync_q   <= 2'h0;
      pulse_sync_q <= 2'h0;
    end
    else
    begin
      ref_sync_q   <= {ref_sync_q[0], ref_compare_clock};
      pulse_sync_q <= {pulse_sync_q[0], detector_pulse};
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      out_a <= 1'b0;
    else
    begin
      case (sec_ref.out_a_func)
        ssrb_pkg::OA_GP:    out_a <= ctrl.out_a;
        ssrb_pkg::OA_PULSE: out_a <= pulse_sync_q[1];
        default:            out_a <= ref_sync_q[1];
      endcase
    end
  end

  // output c is open drain style: low when driven, else released
  assign out_c_o    = 1'b0;
  assign out_c_oe_n = ctrl.out_c;

  assign vmult_on    = (sec_ref.vmult_ctrl != 3'h0);
  assign vmult_range = sec_ref.vmult_ctrl[1:0];

  // detector tristate overrides the program field
  always_comb
  begin
    high_current_pump_en = 1'b0;
    low_current_pump_en  = 1'b0;
    if (!ctrl.detector_tristate && !ctrl.main_standby)
    begin
      case (main_div.pd_program)
        3'h0:                 ;
        ssrb_pkg::PDP_LOW:    low_current_pump_en = 1'b1;
        3'h2:                 high_current_pump_en = 1'b1;
        3'h3:
        begin
          high_current_pump_en = 1'b1;
          low_current_pump_en  = 1'b1;
        end
        default:              high_current_pump_en = 1'b1;
      endcase
    end
  end

  assign ratio_8to1       = main_div.current_ratio;
  assign lock_window_long = main_div.lock_window;
  assign ext_ref_sel      = mode_sync_q[2] & ctrl.out_b_xref;

endmodule

// >>> verif/ssrb_host.sv
// host model: shifts frames into the serial port, msb first
`timescale 1ns/1ps
module ssrb_host (
  output logic ser_clk,
  output logic ser_data,
  output logic ser_enable_n
);
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b1;
    ser_enable_n = 1'b1;
  end
  // link clock runs only inside a frame, 48 ns period
  task automatic send(input int n, input logic [31:0] d);
    #3 ser_enable_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      ser_data = d[i];
      #24 ser_clk = 1'b1;
      #24 ser_clk = 1'b0;
    end
    #24 ser_enable_n = 1'b1;
    // released line must not keep showing the last bit
    ser_data = ~ser_data;
  endtask
endmodule

// >>> verif/ssrb_checker.sv
// checker: port-level assertions for the serial register bank
`timescale 1ns/1ps
module ssrb_checker (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        ser_enable_n,
  input ssrb_pkg::ssrb_ctrl_t ctrl,
  input ssrb_pkg::ssrb_sref_t sec_ref,
  input ssrb_pkg::ssrb_main_t main_div,
  input wire logic [15:0] main_ref_active,
  input wire logic [15:0] sec_div_active,
  input wire logic [15:0] main_ref_holding,
  input wire logic [15:0] secondary_divider_holding,
  input wire logic        out_a,
  input wire logic        out_c_o,
  input wire logic        out_c_oe_n,
  input wire logic        vmult_on,
  input wire logic        high_current_pump_en,
  input wire logic        low_current_pump_en,
  input wire logic        ratio_8to1,
  input wire logic        lock_window_long
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_out_c;
    out_c_oe_n == ctrl.out_c && out_c_o == 1'b0;
  endproperty
  a_out_c: assert property (p_out_c) else $error("out c wrong");
  property p_out_a;
    (sec_ref.out_a_func == 2'h0 && $stable(ctrl) && $stable(sec_ref))[*3]
      |-> out_a == ctrl.out_a;
  endproperty
  a_out_a: assert property (p_out_a) else $error("out a wrong");
  property p_float;
    ctrl.detector_tristate |-> !high_current_pump_en && !low_current_pump_en;
  endproperty
  a_float: assert property (p_float) else $error("pump on");
  property p_low;
    main_div.pd_program == 3'h1 && !ctrl.detector_tristate
      && !ctrl.main_standby |-> low_current_pump_en && !high_current_pump_en;
  endproperty
  a_low: assert property (p_low) else $error("pump select");
  property p_vmult;
    vmult_on == (sec_ref.vmult_ctrl != 3'h0);
  endproperty
  a_vmult: assert property (p_vmult) else $error("multiplier");
  property p_fields;
    ratio_8to1 == main_div.current_ratio
      && lock_window_long == main_div.lock_window;
  endproperty
  a_fields: assert property (p_fields) else $error("n fields");
  property p_dbuf;
    $changed(main_ref_active) || $changed(sec_div_active) |->
      main_ref_active == main_ref_holding
      && sec_div_active == secondary_divider_holding;
  endproperty
  a_dbuf: assert property (p_dbuf) else $error("active copy");
  property p_quiet;
    $changed({ctrl, sec_ref, main_div}) |-> ser_enable_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("mid frame");
  cover property ($changed(main_ref_active));
  cover property ($fell(ctrl.detector_tristate));
  cover property ($rose(out_a) && sec_ref.out_a_func != 2'h0);
endmodule
bind ssrb_bank ssrb_checker chk (.clock, .rst_n, .ser_enable_n, .ctrl,
  .sec_ref, .main_div, .main_ref_active, .sec_div_active,
  .main_ref_holding, .secondary_divider_holding, .out_a, .out_c_o,
  .out_c_oe_n, .vmult_on, .high_current_pump_en, .low_current_pump_en,
  .ratio_8to1, .lock_window_long);

// >>> verif/testbench.sv
// testbench: serial loads, refusals, output mux, reset
`timescale 1ns/1ps
module testbench;
  logic clock, rst_n, ser_clk, ser_data, ser_enable_n, mode_pin;
  logic ref_compare_clock, detector_pulse, out_a, out_c_o, out_c_oe_n;
  logic vmult_on, high_current_pump_en, low_current_pump_en;
  logic ratio_8to1, lock_window_long, ext_ref_sel;
  ssrb_pkg::ssrb_ctrl_t ctrl;
  ssrb_pkg::ssrb_sref_t sec_ref;
  ssrb_pkg::ssrb_main_t main_div;
  logic [15:0] main_ref_active, sec_div_active, main_ref_holding;
  logic [15:0] secondary_divider_holding, e_mh, e_ma, e_sh, e_sa, e_dac;
  logic [7:0]  dac1_code, dac2_code, e_ctrl;
  logic [23:0] e_sref, e_main;
  int          mismatches, tests_run;
  // detectors floated first, c6 set, test and coefficient bits 0, n23 set
  int          row_len [12] = '{8, 32, 16, 32, 24, 8, 32, 32, 16, 32, 32, 32};
  logic [31:0] row_dat [12] = '{32'h58, 32'h050201e6, 32'h1e60,
    32'h04001388, 32'h895f90, 32'h40, 32'h03000080, 32'h0300ff00,
    32'h1234, 32'h07004321, 32'h06895f91, 32'h080000a0};
  ssrb_host host (.ser_clk, .ser_data, .ser_enable_n);
  ssrb_bank dut (.clock, .rst_n, .ser_clk, .ser_data, .ser_enable_n,
    .mode_pin, .ref_compare_clock, .detector_pulse, .ctrl, .sec_ref,
    .main_div, .main_ref_active, .sec_div_active, .main_ref_holding,
    .secondary_divider_holding, .dac1_code, .dac2_code, .out_a, .out_c_o,
    .out_c_oe_n, .vmult_on, .vmult_range(), .high_current_pump_en,
    .low_current_pump_en, .ratio_8to1, .lock_window_long, .ext_ref_sel);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [23:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_all();
    chk("ctrl", 24'(e_ctrl), 24'(ctrl));
    chk("sec_ref", e_sref, sec_ref);
    chk("main_div", e_main, main_div);
    chk("main_hold", 24'(e_mh), 24'(main_ref_holding));
    chk("main_act", 24'(e_ma), 24'(main_ref_active));
    chk("sec_hold", 24'(e_sh), 24'(secondary_divider_holding));
    chk("sec_act", 24'(e_sa), 24'(sec_div_active));
    chk("dac", 24'(e_dac), 24'({dac2_code, dac1_code}));
    chk("out_c_oe_n", 24'(e_ctrl[5]), 24'(out_c_oe_n));
    chk("ext_ref", 24'(e_ctrl[6] & mode_pin), 24'(ext_ref_sel));
  endtask
  task automatic reset_model();
    e_ctrl = ssrb_pkg::CTRL_RST;
    {e_sref, e_main, e_mh, e_ma, e_sh, e_sa, e_dac} = '0;
  endtask
  // length picks the target unless an address nibble is carried
  task automatic frame(input int n, input logic [31:0] d);
    logic [3:0] a;
    host.send(n, d);
    a = n == 32 ? d[27:24] : n == 8 ? 4'h8 : n == 16 ? 4'h7
      : n == 24 ? 4'h6 : 4'h0;
    case (a)
      4'h3: e_dac = d[15:0];
      4'h4: e_sh = d[15:0];
      4'h5: e_sref = d[23:0];
      4'h6: {e_main, e_ma, e_sa} = {d[23:0], e_mh, e_sh};
      4'h7: e_mh = d[15:0];
      4'h8: e_ctrl = d[7:0];
      default: ;
    endcase
    repeat (8) @(posedge clock);
    check_all();
    $display("frame of %0d bits %h done", n, d);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    give_verdict();
  end
  initial
  begin
    rst_n = 1'b0;
    mode_pin = 1'b1;
    ref_compare_clock = 1'b0;
    detector_pulse = 1'b0;
    mismatches = 0;
    tests_run = 0;
    reset_model();
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check_all();
    for (int i = 0; i < 12; i++)
      frame(row_len[i], row_dat[i]);
    frame(12, 32'h00000abc);
    frame(32, 32'h09123456);
    ref_compare_clock <= 1'b1;
    // c7 is set, so general-purpose mode shows 1 and pulse mode 0
    for (int i = 0; i < 4; i++)
    begin
      frame(32, {8'h05, 2'h0, 2'(i), 3'(i), 1'b0, 16'h01e6});
      chk("out_a", 24'(i != 3), 24'(out_a));
      chk("vmult_on", 24'(i != 0), 24'(vmult_on));
    end
    rst_n <= 1'b0;
    @(posedge clock);
    reset_model();
    check_all();
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    frame(24, 32'h00895f90);
    give_verdict();
  end
endmodule
